// [verilog/sys_ctrl_pkg.sv]
package sys_ctrl_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_SYSTEM_CONFIG_0       = 8'h00;
    localparam logic [7:0] OFF_PIN_IRQ_MODE_CTRL     = 8'h04;
    localparam logic [7:0] OFF_IRQ_LATENCY_CTRL      = 8'h38;
    localparam logic [7:0] OFF_TICK_TIMER_CTRL       = 8'h3C;
    localparam logic [7:0] OFF_DEBUG_PIN_CTRL        = 8'h40;
    localparam logic [7:0] OFF_PERIPHERAL_SOFT_RESET = 8'h44;
    localparam logic [7:0] OFF_RTC_DOMAIN_RESET      = 8'h48;
    localparam logic [7:0] OFF_SYSCON_WRITE_UNLOCK   = 8'h50;
    localparam logic [7:0] OFF_CLOCK_UNIT_UNLOCK     = 8'h60;

    // Write keys
    localparam logic [15:0] WRITE_KEY   = 16'h5A69;
    localparam logic [30:0] UNLOCK_KEY  = 31'h2AD5334C;
    localparam int          KEY_LSB     = 16;

    // Field positions
    localparam int TICK_CORE_SEL_BIT    = 25;
    localparam int TICK_INEXACT_BIT     = 24;
    localparam int TICK_COUNT_W         = 24;
    localparam int DBG_DEEP_SLEEP_BIT   = 1;
    localparam int STALL_RST_EN_BIT     = 0;
    localparam int PIN_AUTO_INHIBIT_BIT = 1;
    localparam int PIN_GEN_SEL_BIT      = 0;

    // Peripheral reset bit positions
    localparam int PRST_UART0     = 0;
    localparam int PRST_UART1     = 1;
    localparam int PRST_I2C       = 2;
    localparam int PRST_LPUART    = 3;
    localparam int PRST_SPI       = 4;
    localparam int PRST_LPTIM     = 5;
    localparam int PRST_BASETIM   = 6;
    localparam int PRST_SYSCON    = 7;
    localparam int PRST_PCA       = 8;
    localparam int PRST_ONEWIRE   = 9;
    localparam int PRST_ADVTIM    = 10;
    localparam int PRST_GPTIM     = 11;
    localparam int PRST_WWDG      = 12;
    localparam int PRST_ADC       = 13;
    localparam int PRST_AWK       = 14;
    localparam int PRST_CLKTRIM   = 16;
    localparam int PRST_LVD       = 18;
    localparam int PRST_BEEP      = 19;
    localparam int PRST_DEBUG     = 20;
    localparam int PRST_GPIOA     = 24;
    localparam int PRST_GPIOB     = 25;
    localparam int PRST_GPIOC     = 26;
    localparam int PRST_GPIOD     = 27;
    localparam int PRST_CHECKSUM  = 28;

    // Implemented bits of the peripheral reset register
    localparam logic [31:0] PERI_RST_MASK = 32'h1F1D7FFF;

    // Reset values
    localparam logic [7:0]  RST_IRQ_LATENCY   = 8'h00;
    localparam logic [31:0] RST_TICK_CTRL     = 32'h01009C3F;
    localparam logic        RST_DEBUG_PIN_SEL = 1'b1;
    localparam logic [31:0] RST_PERI_RST      = 32'h00000000;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;

    typedef struct packed {
        logic tick_core_sel;
        logic core_tick_src;
        logic auto_inhibit;
        logic gen_select;
        logic deep_sleep;
        logic dbg_sleep_block;
        logic debug_mode;
        logic stall_rst_en;
        logic lockup;
    } status_src_type;

endpackage

// [verilog/write_unlock.sv]
// Write protection latch; bit 0 of the unlock register
module write_unlock
    import sys_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // Register write
    input  wire logic        wr_in,
    input  wire logic [31:0] wdata_in,
    // State
    output logic             unlocked_out
);

    logic unlocked_nxt;

    // Writes without the long key are ignored, so protection is never dropped by accident
    assign unlocked_nxt = (wr_in && wdata_in[31:1] == UNLOCK_KEY) ? wdata_in[0]
                                                                   : unlocked_out;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            unlocked_out <= 1'b0;
        end else begin
            unlocked_out <= unlocked_nxt;
        end
    end

endmodule

// [verilog/ctrl_status_out.sv]
// Registered decisions derived from control bits and system inputs
module ctrl_status_out
    import sys_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic           ref_clk_in,
    input  wire logic           rst_in,
    // Sources
    input  wire status_src_type src_in,
    // Decisions
    output logic                tick_use_core_clk_out,
    output logic                pin_irq_deep_mode_out,
    output logic                deep_sleep_permit_out,
    output logic                lockup_reset_req_out
);

    wire tick_core_nxt  = src_in.tick_core_sel | src_in.core_tick_src;
    wire auto_deep      = ~src_in.auto_inhibit & src_in.deep_sleep;
    wire pin_deep_nxt   = src_in.gen_select | auto_deep;
    wire sleep_ok_nxt   = ~(src_in.debug_mode & src_in.dbg_sleep_block);
    wire lockup_rst_nxt = src_in.stall_rst_en & src_in.lockup;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            tick_use_core_clk_out <= 1'b0;
            pin_irq_deep_mode_out <= 1'b0;
            deep_sleep_permit_out <= 1'b1;
            lockup_reset_req_out  <= 1'b0;
        end else begin
            tick_use_core_clk_out <= tick_core_nxt;
            pin_irq_deep_mode_out <= pin_deep_nxt;
            deep_sleep_permit_out <= sleep_ok_nxt;
            lockup_reset_req_out  <= lockup_rst_nxt;
        end
    end

endmodule

// [verilog/sys_ctrl_protected_regs.sv]
// Function
// - Eight-bit interrupt delay field, reset zero, writable only with clock unit unlocked.
// - Tick control bit 25 picks tick reference: zero bus clock/4, one core clock.
// - Core clock drives tick when own select or processor source bit is one.
// - Calibration inexact flag, read/write, resets to one; one means inexact.
// - Tick ten-millisecond count, 24 bits read/write, resets to 9C3F.
// - Keyed registers accept a write only when upper half equals 5A69.
// - Debug pin select bit: zero peripheral function, one serial debug; resets one.
// - Debug pin select writes also need clock unit protection released.
// - Peripheral reset register, one bit per module, resets zero, reserved bits zero.
// - RTC domain reset bit holds RTC in reset; keyed and clock-unit protected.
// - Writing 55AA6699 to an unlock register releases its protection.
// - Unlock bit 0 shows protection state and resets to zero.
// - Configuration bit 1 blocks deep sleep entry while debugging.
// - Configuration bit 0 lets a processor lockup reset the whole chip.
// - Configuration and pin interrupt mode writes need system unlock plus key.
// - Auto switch inhibit zero forces deep-sleep pin interrupt mode in deep sleep.
// - Pin interrupt generation select: zero active/sleep, one deep sleep; resets zero.
module sys_ctrl_protected_regs
    import sys_ctrl_pkg::*;
#(
    parameter int LATENCY_W = 8,
    parameter int PERI_W    = 32
) (
    // Clock and reset
    input  wire logic                    ref_clk_in,
    input  wire logic                    rst_in,

    // Register port
    input  wire logic [7:0]              addr_in,
    input  wire logic [31:0]             wdata_in,
    input  wire logic                    wr_in,
    input  wire logic                    rd_in,
    output logic [31:0]                  rdata_out,

    // System inputs
    input  wire logic                    core_tick_source_bit_in,
    input  wire logic                    deep_sleep_in,
    input  wire logic                    debug_mode_in,
    input  wire logic                    lockup_in,

    // Tick timer
    output logic                         tick_use_core_clk_out,
    output logic                         calib_inexact_flag_out,
    output logic [TICK_COUNT_W-1:0]      tick_ten_ms_count_out,

    // Processor and debug
    output logic [LATENCY_W-1:0]         interrupt_delay_setting_out,
    output logic                         debug_pin_function_select_out,
    output logic                         deep_sleep_permit_out,
    output logic                         lockup_reset_req_out,

    // Pin interrupts
    output logic                         pin_irq_deep_mode_out,

    // Module resets
    output logic [PERI_W-1:0]            peripheral_rst_out,
    output logic                         rtc_domain_rst_out,
    output logic                         uart0_rst_out,
    output logic                         uart1_rst_out,
    output logic                         i2c_rst_out,
    output logic                         lpuart_rst_out,
    output logic                         spi_rst_out,
    output logic                         lptim_rst_out,
    output logic                         basetim_rst_out,
    output logic                         syscon_rst_out,
    output logic                         pca_rst_out,
    output logic                         onewire_rst_out,
    output logic                         adv_timer_rst_out,
    output logic                         gp_timer_rst_out,
    output logic                         wwdg_rst_out,
    output logic                         adc_rst_out,
    output logic                         awk_rst_out,
    output logic                         clk_trim_rst_out,
    output logic                         low_voltage_detect_reset_out,
    output logic                         beep_rst_out,
    output logic                         debug_unit_reset_out,
    output logic                         gpioa_rst_out,
    output logic                         gpiob_rst_out,
    output logic                         gpioc_rst_out,
    output logic                         gpiod_rst_out,
    output logic                         checksum_unit_reset_out
);

    function automatic logic key_ok(input logic [31:0] data);
        key_ok = (data[31:KEY_LSB] == WRITE_KEY);
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    bus_req_type    req;
    status_src_type src;

    logic                    clk_unlocked;
    logic                    sys_unlocked;

    logic [LATENCY_W-1:0]    latency_r;
    logic                    tick_core_sel_r;
    logic                    calib_inexact_r;
    logic [TICK_COUNT_W-1:0] tick_count_r;
    logic                    debug_pin_sel_r;
    logic [PERI_W-1:0]       peri_rst_r;
    logic                    rtc_rst_r;

    logic                    dbg_sleep_block_r;
    logic                    stall_rst_en_r;
    logic                    pin_auto_inhibit_r;
    logic                    pin_gen_sel_r;

    logic [31:0]             rdata_r;
    logic [31:0]             rdata_nxt;

    assign req.addr  = addr_in;
    assign req.wdata = wdata_in;
    assign req.wr    = wr_in;
    assign req.rd    = rd_in;

    // Address decode
    wire hit_cfg0    = hit(req.addr, OFF_SYSTEM_CONFIG_0);
    wire hit_pin     = hit(req.addr, OFF_PIN_IRQ_MODE_CTRL);
    wire hit_lat     = hit(req.addr, OFF_IRQ_LATENCY_CTRL);
    wire hit_tick    = hit(req.addr, OFF_TICK_TIMER_CTRL);
    wire hit_dbg     = hit(req.addr, OFF_DEBUG_PIN_CTRL);
    wire hit_peri    = hit(req.addr, OFF_PERIPHERAL_SOFT_RESET);
    wire hit_rtc     = hit(req.addr, OFF_RTC_DOMAIN_RESET);
    wire hit_sys_ul  = hit(req.addr, OFF_SYSCON_WRITE_UNLOCK);
    wire hit_clk_ul  = hit(req.addr, OFF_CLOCK_UNIT_UNLOCK);

    wire keyed       = key_ok(req.wdata);

    // Write enables; a failed guard simply drops the write, with no error reported
    wire we_cfg0     = req.wr && hit_cfg0 && keyed && sys_unlocked;
    wire we_pin      = req.wr && hit_pin && keyed && sys_unlocked;
    wire we_lat      = req.wr && hit_lat && clk_unlocked;
    wire we_tick     = req.wr && hit_tick;
    wire we_dbg      = req.wr && hit_dbg && keyed && clk_unlocked;
    wire we_peri     = req.wr && hit_peri;
    wire we_rtc      = req.wr && hit_rtc && keyed && clk_unlocked;
    wire we_sys_ul   = req.wr && hit_sys_ul;
    wire we_clk_ul   = req.wr && hit_clk_ul;

    write_unlock u_clk_unlock (
        .ref_clk_in   (ref_clk_in),
        .rst_in       (rst_in),
        .wr_in        (we_clk_ul),
        .wdata_in     (req.wdata),
        .unlocked_out (clk_unlocked)
    );

    write_unlock u_sys_unlock (
        .ref_clk_in   (ref_clk_in),
        .rst_in       (rst_in),
        .wr_in        (we_sys_ul),
        .wdata_in     (req.wdata),
        .unlocked_out (sys_unlocked)
    );

    // Interrupt delay setting
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            latency_r <= RST_IRQ_LATENCY;
        end else if (we_lat) begin
            latency_r <= req.wdata[LATENCY_W-1:0];
        end
    end

    // Tick timer control: not keyed and not protected
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            tick_core_sel_r <= RST_TICK_CTRL[TICK_CORE_SEL_BIT];
            calib_inexact_r <= RST_TICK_CTRL[TICK_INEXACT_BIT];
            tick_count_r    <= RST_TICK_CTRL[TICK_COUNT_W-1:0];
        end else if (we_tick) begin
            tick_core_sel_r <= req.wdata[TICK_CORE_SEL_BIT];
            calib_inexact_r <= req.wdata[TICK_INEXACT_BIT];
            tick_count_r    <= req.wdata[TICK_COUNT_W-1:0];
        end
    end

    // Debug pin function
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            debug_pin_sel_r <= RST_DEBUG_PIN_SEL;
        end else if (we_dbg) begin
            debug_pin_sel_r <= req.wdata[0];
        end
    end

    // Peripheral soft resets; reserved positions stay zero
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            peri_rst_r <= RST_PERI_RST[PERI_W-1:0];
        end else if (we_peri) begin
            peri_rst_r <= req.wdata[PERI_W-1:0] & PERI_RST_MASK[PERI_W-1:0];
        end
    end

    // RTC domain reset stays asserted until software clears it
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rtc_rst_r <= 1'b0;
        end else if (we_rtc) begin
            rtc_rst_r <= req.wdata[0];
        end
    end

    // System configuration
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            dbg_sleep_block_r <= 1'b0;
            stall_rst_en_r    <= 1'b0;
        end else if (we_cfg0) begin
            dbg_sleep_block_r <= req.wdata[DBG_DEEP_SLEEP_BIT];
            stall_rst_en_r    <= req.wdata[STALL_RST_EN_BIT];
        end
    end

    // Pin interrupt mode
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pin_auto_inhibit_r <= 1'b0;
            pin_gen_sel_r      <= 1'b0;
        end else if (we_pin) begin
            pin_auto_inhibit_r <= req.wdata[PIN_AUTO_INHIBIT_BIT];
            pin_gen_sel_r      <= req.wdata[PIN_GEN_SEL_BIT];
        end
    end

    // Read mux; key fields and unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (req.rd) begin
            case (1'b1)
                hit_cfg0: begin
                    rdata_nxt[DBG_DEEP_SLEEP_BIT] = dbg_sleep_block_r;
                    rdata_nxt[STALL_RST_EN_BIT]   = stall_rst_en_r;
                end
                hit_pin: begin
                    rdata_nxt[PIN_AUTO_INHIBIT_BIT] = pin_auto_inhibit_r;
                    rdata_nxt[PIN_GEN_SEL_BIT]      = pin_gen_sel_r;
                end
                hit_lat: begin
                    rdata_nxt[LATENCY_W-1:0] = latency_r;
                end
                hit_tick: begin
                    rdata_nxt[TICK_CORE_SEL_BIT]  = tick_core_sel_r;
                    rdata_nxt[TICK_INEXACT_BIT]   = calib_inexact_r;
                    rdata_nxt[TICK_COUNT_W-1:0]   = tick_count_r;
                end
                hit_dbg: begin
                    rdata_nxt[0] = debug_pin_sel_r;
                end
                hit_peri: begin
                    rdata_nxt[PERI_W-1:0] = peri_rst_r;
                end
                hit_rtc: begin
                    rdata_nxt[0] = rtc_rst_r;
                end
                hit_sys_ul: begin
                    rdata_nxt[0] = sys_unlocked;
                end
                hit_clk_ul: begin
                    rdata_nxt[0] = clk_unlocked;
                end
                default: begin
                    rdata_nxt = 32'h00000000;
                end
            endcase
        end
    end

    // Read data live only in the cycle after the strobe
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_out = rdata_r;

    // Derived decisions
    assign src.tick_core_sel   = tick_core_sel_r;
    assign src.core_tick_src   = core_tick_source_bit_in;
    assign src.auto_inhibit    = pin_auto_inhibit_r;
    assign src.gen_select      = pin_gen_sel_r;
    assign src.deep_sleep      = deep_sleep_in;
    assign src.dbg_sleep_block = dbg_sleep_block_r;
    assign src.debug_mode      = debug_mode_in;
    assign src.stall_rst_en    = stall_rst_en_r;
    assign src.lockup          = lockup_in;

    // Tick reference validity against bus clock is left to software
    ctrl_status_out u_status (
        .ref_clk_in            (ref_clk_in),
        .rst_in                (rst_in),
        .src_in                (src),
        .tick_use_core_clk_out (tick_use_core_clk_out),
        .pin_irq_deep_mode_out (pin_irq_deep_mode_out),
        .deep_sleep_permit_out (deep_sleep_permit_out),
        .lockup_reset_req_out  (lockup_reset_req_out)
    );

    // Register-direct outputs
    assign calib_inexact_flag_out        = calib_inexact_r;
    assign tick_ten_ms_count_out         = tick_count_r;
    assign interrupt_delay_setting_out   = latency_r;
    assign debug_pin_function_select_out = debug_pin_sel_r;
    assign rtc_domain_rst_out            = rtc_rst_r;
    assign peripheral_rst_out            = peri_rst_r;

    // Per-module reset fan-out
    assign uart0_rst_out                = peri_rst_r[PRST_UART0];
    assign uart1_rst_out                = peri_rst_r[PRST_UART1];
    assign i2c_rst_out                  = peri_rst_r[PRST_I2C];
    assign lpuart_rst_out               = peri_rst_r[PRST_LPUART];
    assign spi_rst_out                  = peri_rst_r[PRST_SPI];
    assign lptim_rst_out                = peri_rst_r[PRST_LPTIM];
    assign basetim_rst_out              = peri_rst_r[PRST_BASETIM];
    assign syscon_rst_out               = peri_rst_r[PRST_SYSCON];
    assign pca_rst_out                  = peri_rst_r[PRST_PCA];
    assign onewire_rst_out              = peri_rst_r[PRST_ONEWIRE];
    assign adv_timer_rst_out            = peri_rst_r[PRST_ADVTIM];
    assign gp_timer_rst_out             = peri_rst_r[PRST_GPTIM];
    assign wwdg_rst_out                 = peri_rst_r[PRST_WWDG];
    assign adc_rst_out                  = peri_rst_r[PRST_ADC];
    assign awk_rst_out                  = peri_rst_r[PRST_AWK];
    assign clk_trim_rst_out             = peri_rst_r[PRST_CLKTRIM];
    assign low_voltage_detect_reset_out = peri_rst_r[PRST_LVD];
    assign beep_rst_out                 = peri_rst_r[PRST_BEEP];
    assign debug_unit_reset_out         = peri_rst_r[PRST_DEBUG];
    assign gpioa_rst_out                = peri_rst_r[PRST_GPIOA];
    assign gpiob_rst_out                = peri_rst_r[PRST_GPIOB];
    assign gpioc_rst_out                = peri_rst_r[PRST_GPIOC];
    assign gpiod_rst_out                = peri_rst_r[PRST_GPIOD];
    assign checksum_unit_reset_out      = peri_rst_r[PRST_CHECKSUM];

endmodule

// [tb/sys_ctrl_assertions.sv]
module sys_ctrl_assertions
    import sys_ctrl_pkg::*;
#(
    parameter int PERI_W = 32
) (
    input wire logic              ref_clk_in,
    input wire logic              rst_in,
    input wire logic [7:0]        addr_in,
    input wire logic [31:0]       wdata_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic [31:0]       rdata_out,
    input wire logic              core_tick_source_bit_in,
    input wire logic              debug_mode_in,
    input wire logic              lockup_in,
    input wire logic              tick_use_core_clk_out,
    input wire logic              calib_inexact_flag_out,
    input wire logic [23:0]       tick_ten_ms_count_out,
    input wire logic              debug_pin_function_select_out,
    input wire logic              deep_sleep_permit_out,
    input wire logic              lockup_reset_req_out,
    input wire logic [PERI_W-1:0] peripheral_rst_out,
    input wire logic              rtc_domain_rst_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside read slot");
    tick_core_a: assert property ($past(core_tick_source_bit_in) |-> tick_use_core_clk_out)
        else $error("core tick source ignored");
    lockup_gate_a: assert property (lockup_reset_req_out |-> $past(lockup_in))
        else $error("lockup reset without lockup");
    sleep_permit_a: assert property (!$past(debug_mode_in) |-> deep_sleep_permit_out)
        else $error("deep sleep blocked outside debug");
    dbg_key_a: assert property (wr_in && addr_in == 8'h40 && wdata_in[31:16] != WRITE_KEY
        |=> $stable(debug_pin_function_select_out)) else $error("bad key changed pin select");
    rtc_key_a: assert property (wr_in && addr_in == 8'h48 && wdata_in[31:16] != WRITE_KEY
        |=> $stable(rtc_domain_rst_out)) else $error("bad key changed rtc reset");
    peri_write_a: assert property (wr_in && addr_in == 8'h44 |=>
        peripheral_rst_out == ($past(wdata_in) & PERI_RST_MASK)) else $error("peri reset");
    peri_hold_a: assert property (!(wr_in && addr_in == 8'h44) |=> $stable(peripheral_rst_out))
        else $error("peripheral reset changed without write");
    tick_write_a: assert property (wr_in && addr_in == 8'h3C |=> tick_ten_ms_count_out ==
        $past(wdata_in[23:0]) && calib_inexact_flag_out == $past(wdata_in[24]))
        else $error("tick control write lost");
    dbg_read_a: assert property (rd_in && addr_in == 8'h40 |=>
        rdata_out == {31'h0, debug_pin_function_select_out}) else $error("pin read");
    c_peri: cover property (wr_in && addr_in == 8'h44);
    c_lockup: cover property (lockup_reset_req_out);
    c_pin: cover property ($fell(debug_pin_function_select_out));
endmodule

// [tb/tb_top.sv]
module tb_top
    import sys_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in, rst_in, wr_in, rd_in, cts, dsl, dbg, lk;
    logic tuc, cif, dps, dsp, lrr, pdm, rtc;
    logic [7:0]  addr, ids;
    logic [23:0] cnt;
    logic [31:0] wdata, rdata, prst, pr;
    assign {pr[31:29], pr[23:21], pr[17], pr[15]} = 8'h00;
    int err_total = 0;
    int total_checks = 0;
    logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h50, 8'h60, 8'h08};
    logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0, 32'h01009C3F, 32'h1, 32'h0, 32'h0, 32'h0,
                            32'h0, 32'h0};

    sys_ctrl_protected_regs i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
        .core_tick_source_bit_in(cts), .deep_sleep_in(dsl), .debug_mode_in(dbg),
        .lockup_in(lk), .tick_use_core_clk_out(tuc), .calib_inexact_flag_out(cif),
        .tick_ten_ms_count_out(cnt), .interrupt_delay_setting_out(ids),
        .debug_pin_function_select_out(dps), .deep_sleep_permit_out(dsp),
        .lockup_reset_req_out(lrr), .pin_irq_deep_mode_out(pdm), .peripheral_rst_out(prst),
        .rtc_domain_rst_out(rtc), .uart0_rst_out(pr[0]), .uart1_rst_out(pr[1]),
        .i2c_rst_out(pr[2]), .lpuart_rst_out(pr[3]), .spi_rst_out(pr[4]),
        .lptim_rst_out(pr[5]), .basetim_rst_out(pr[6]), .syscon_rst_out(pr[7]),
        .pca_rst_out(pr[8]), .onewire_rst_out(pr[9]), .adv_timer_rst_out(pr[10]),
        .gp_timer_rst_out(pr[11]), .wwdg_rst_out(pr[12]), .adc_rst_out(pr[13]),
        .awk_rst_out(pr[14]), .clk_trim_rst_out(pr[16]), .low_voltage_detect_reset_out(pr[18]),
        .beep_rst_out(pr[19]), .debug_unit_reset_out(pr[20]), .gpioa_rst_out(pr[24]),
        .gpiob_rst_out(pr[25]), .gpioc_rst_out(pr[26]), .gpiod_rst_out(pr[27]),
        .checksum_unit_reset_out(pr[28]));

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in) {wr_in, addr, wdata} <= {1'b1, a, d};
        @(posedge ref_clk_in) wr_in <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_in) {rd_in, addr} <= {1'b1, a};
        @(posedge ref_clk_in) rd_in <= 1'b0;
        #1 chk($sformatf("rdata at %h", a), rdata, exp);
    endtask
    // Derived outputs lag their sources by one register stage
    task settle;
        repeat (2) @(posedge ref_clk_in);
        #1;
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #50000 err_total++;
        end_sim;
    end
    initial begin
        {rst_in, wr_in, rd_in, addr, wdata, cts, dsl, dbg, lk} = {1'b1, 46'h0};
        repeat (5) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
        $display("test reset values done");
        wr(8'h40, 32'h5A690000);
        chk("pin select", {31'h0, dps}, 32'h1);
        wr(8'h38, 32'h000000A5);
        chk("irq delay", {24'h0, ids}, 32'h0);
        wr(8'h48, 32'h5A690001);
        chk("rtc reset", {31'h0, rtc}, 32'h0);
        wr(8'h00, 32'h5A690003);
        rd(8'h00, 32'h0);
        $display("test locked writes done");
        wr(8'h60, 32'h55AA6699);
        rd(8'h60, 32'h1);
        wr(8'h40, 32'h12340000);
        chk("pin select", {31'h0, dps}, 32'h1);
        wr(8'h40, 32'h5A690000);
        chk("pin select", {31'h0, dps}, 32'h0);
        wr(8'h38, 32'h5A6900A5);
        rd(8'h38, 32'hA5);
        wr(8'h48, 32'h5A690001);
        rd(8'h48, 32'h1);
        wr(8'h48, 32'h12340000);
        rd(8'h48, 32'h1);
        $display("test clock unit unlock done");
        wr(8'h50, 32'h55AA6699);
        wr(8'h00, 32'h12340003);
        rd(8'h00, 32'h0);
        wr(8'h00, 32'h5A690003);
        rd(8'h00, 32'h3);
        @(posedge ref_clk_in) {dbg, lk} <= 2'b11;
        settle;
        chk("sleep permit", {31'h0, dsp}, 32'h0);
        chk("lockup req", {31'h0, lrr}, 32'h1);
        wr(8'h00, 32'h5A690000);
        settle;
        chk("sleep permit", {31'h0, dsp}, 32'h1);
        chk("lockup req", {31'h0, lrr}, 32'h0);
        wr(8'h04, 32'h5A690002);
        @(posedge ref_clk_in) dsl <= 1'b1;
        settle;
        chk("pin deep", {31'h0, pdm}, 32'h0);
        wr(8'h04, 32'h5A690000);
        settle;
        chk("pin deep", {31'h0, pdm}, 32'h1);
        @(posedge ref_clk_in) dsl <= 1'b0;
        wr(8'h04, 32'h5A690001);
        settle;
        chk("pin deep", {31'h0, pdm}, 32'h1);
        $display("test system config done");
        wr(8'h3C, 32'hFEABCDEF);
        rd(8'h3C, 32'h02ABCDEF);
        chk("tick core", {31'h0, tuc}, 32'h1);
        wr(8'h3C, 32'h0);
        settle;
        chk("tick core", {31'h0, tuc}, 32'h0);
        chk("tick count", {7'h0, cif, cnt}, 32'h0);
        @(posedge ref_clk_in) cts <= 1'b1;
        settle;
        chk("tick core", {31'h0, tuc}, 32'h1);
        $display("test tick done");
        wr(8'h44, 32'hFFFFFFFF);
        rd(8'h44, 32'h1F1D7FFF);
        chk("unit resets", pr, PERI_RST_MASK);
        wr(8'h44, 32'h0);
        chk("peri reset", prst, 32'h0);
        chk("unit resets", pr, 32'h0);
        wr(8'h60, 32'h55AA6698);
        rd(8'h60, 32'h0);
        wr(8'h40, 32'h5A690001);
        rd(8'h40, 32'h0);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'h0);
        $display("test relock done");
        end_sim;
    end
endmodule

bind sys_ctrl_protected_regs sys_ctrl_assertions #(.PERI_W(PERI_W)) i_chk (.ref_clk_in,
    .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .core_tick_source_bit_in,
    .debug_mode_in, .lockup_in, .tick_use_core_clk_out, .calib_inexact_flag_out,
    .tick_ten_ms_count_out, .debug_pin_function_select_out, .deep_sleep_permit_out,
    .lockup_reset_req_out, .peripheral_rst_out, .rtc_domain_rst_out);
